// ### wdf_defs.vh
// Constants for the fuse-configured watchdog block.
// Included by wdf_top.v and wdf_tick.v; definitions only.
`ifndef WDF_DEFS_VH
`define WDF_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDF_CONFIG_OFF 12'h000
`define WDF_CONTROL_OFF 12'h004
`define WDF_STATUS_OFF 12'h008
`define WDF_IRQ_STAT_OFF 12'h00c
`define WDF_IRQ_MASK_OFF 12'h010
`define WDF_COUNT_OFF 12'h014

// ----------------------------------------------------------------
// Config word field positions
// ----------------------------------------------------------------
`define WDF_PS_LSB 0
`define WDF_PS_MSB 3
`define WDF_PRE_BIT 4
`define WDF_EN_LSB 5
`define WDF_EN_MSB 6
`define WDF_WDIS_BIT 7
`define WDF_WIN_LSB 8
`define WDF_WIN_MSB 9
`define WDF_CFG_RESET 10'h3ff

// ----------------------------------------------------------------
// Control bits and events
// ----------------------------------------------------------------
`define WDF_CTL_SOFT_EN 0
`define WDF_CTL_CLEAR 1
`define WDF_CTL_SLEEP 2
`define WDF_EV_TIMEOUT 0
`define WDF_EV_EARLY 1
`define WDF_EV_BAD_KICK 2
`define WDF_EV_NUM 3

// ----------------------------------------------------------------
// Enable modes and prescaler divides
// ----------------------------------------------------------------
`define WDF_EN_OFF 2'b00
`define WDF_EN_AWAKE 2'b01
`define WDF_EN_SOFT 2'b10
`define WDF_EN_HARD 2'b11
`define WDF_PRE_LONG 8'd128
`define WDF_PRE_SHORT 8'd32

`endif

// ### wdf_tick.v
// Prescaler: one-cycle tick every 128 or 32 run cycles.
// Assumes aclk and a synchronous active-low reset.
`timescale 1ns/1ns
module wdf_tick (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire restart,
  input wire prescale_sel,
  output reg tick
);
`include "wdf_defs.vh"
  reg [7:0] cnt_q;
  wire [7:0] last = prescale_sel ? (`WDF_PRE_LONG - 8'd1) : (`WDF_PRE_SHORT - 8'd1);

  // Count run cycles, wrap and pulse
  always @(posedge aclk) begin
    if (!aresetn || restart || !run) begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'd1;
      tick <= 1'b0;
    end
  end
endmodule // wdf_tick

// ### wdf_top.v
// Watchdog with fuse-style configuration, AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low aresetn, 32-bit bus.
// Summary of operation
// - Prescaler divides by 128 or 32
// - Postscale code 1111 gives 32768, 1110 16384
// - Mode 11 runs always, enable and sleep cannot stop; only a config write stops it
// - Mode 10 runs while software enable set
// - Mode 01 runs awake, stops asleep, ignores enable
// - Mode 00 stopped, software enable disabled
// - Window disable one means non-window mode
// - Window 75, 50, 37.5, 25 percent by code
`timescale 1ns/1ns
module wdf_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wdt_reset_q,
  output reg irq_q
);
`include "wdf_defs.vh"

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [9:0] config_q;
  reg soft_en_q;
  reg sleep_q;
  reg [14:0] post_q;
  reg [`WDF_EV_NUM-1:0] stat_q;
  reg [`WDF_EV_NUM-1:0] mask_q;
  reg [11:0] aw_q;
  reg aw_got_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_got_q;
  reg kick_q;
  reg tick_restart_q;
  wire tick;
  wire [3:0] watchdog_postscale_sel = config_q[`WDF_PS_MSB:`WDF_PS_LSB];
  wire watchdog_prescale_sel = config_q[`WDF_PRE_BIT];
  wire [1:0] watchdog_enable_mode = config_q[`WDF_EN_MSB:`WDF_EN_LSB];
  wire window_disable = config_q[`WDF_WDIS_BIT];
  wire [1:0] window_size_sel = config_q[`WDF_WIN_MSB:`WDF_WIN_LSB];

  // ----------------------------------------------------------------
  // Run decision from enable mode
  // ----------------------------------------------------------------
  reg run;
  always @* begin
    case (watchdog_enable_mode)
      `WDF_EN_HARD: run = 1'b1;
      `WDF_EN_SOFT: run = soft_en_q;
      `WDF_EN_AWAKE: run = !sleep_q;
      default: run = 1'b0;
    endcase
  end

  // Last postscale count: ratio 2^code, top code 2^15
  wire [15:0] ratio = 16'h0001 << watchdog_postscale_sel;
  wire [15:0] ratio_m1 = ratio - 16'h0001;
  wire [14:0] post_last = ratio_m1[14:0];

  // Window opens after closed share; share = 1 - window size
  function [14:0] wdf_open_at;
    input [1:0] sel;
    input [15:0] r;
    begin
      case (sel)
        2'b11: wdf_open_at = {1'b0, r[15:2]} * 15'h0003;
        2'b10: wdf_open_at = {2'b00, r[15:3]} * 15'h0005;
        2'b01: wdf_open_at = {r[15:2], 1'b0};
        default: wdf_open_at = {1'b0, r[15:2]};
      endcase
    end
  endfunction
  wire [14:0] open_at = wdf_open_at(window_size_sel, ratio);
  wire window_open = window_disable || (post_q >= open_at);

  wdf_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .restart(tick_restart_q),
    .prescale_sel(watchdog_prescale_sel),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  wire do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  wire wr_stat = do_write && (aw_q == `WDF_IRQ_STAT_OFF);
  wire wr_ctl = do_write && (aw_q == `WDF_CONTROL_OFF);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (aw_q == `WDF_CONFIG_OFF || aw_q == `WDF_CONTROL_OFF || aw_q == `WDF_IRQ_STAT_OFF
            || aw_q == `WDF_IRQ_MASK_OFF)
          s_axi_bresp <= 2'b00;
        else if (aw_q == `WDF_STATUS_OFF || aw_q == `WDF_COUNT_OFF)
          s_axi_bresp <= 2'b00;
        else
          s_axi_bresp <= 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Config, control, mask registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= `WDF_CFG_RESET;
      soft_en_q <= 1'b0;
      sleep_q <= 1'b0;
      mask_q <= {`WDF_EV_NUM{1'b0}};
      kick_q <= 1'b0;
    end else begin
      kick_q <= wr_ctl && ws_q[0] && w_q[`WDF_CTL_CLEAR];
      if (do_write && aw_q == `WDF_CONFIG_OFF) begin
        if (ws_q[0])
          config_q[7:0] <= w_q[7:0];
        if (ws_q[1])
          config_q[9:8] <= w_q[9:8];
      end
      if (wr_ctl && ws_q[0]) begin
        // Enable bit held low unless mode is software-controlled
        soft_en_q <= w_q[`WDF_CTL_SOFT_EN] && (watchdog_enable_mode == `WDF_EN_SOFT);
        sleep_q <= w_q[`WDF_CTL_SLEEP];
      end else if (watchdog_enable_mode != `WDF_EN_SOFT) begin
        soft_en_q <= 1'b0;
      end
      if (do_write && aw_q == `WDF_IRQ_MASK_OFF && ws_q[0])
        mask_q <= w_q[`WDF_EV_NUM-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Postscaler, window check, timeout
  // ----------------------------------------------------------------
  wire early = kick_q && run && !window_open;
  wire good_kick = kick_q && run && window_open;
  wire bad_kick = kick_q && !run;
  wire timeout = run && tick && (post_q >= post_last);
  always @(posedge aclk) begin
    if (!aresetn) begin
      post_q <= 15'h0000;
      tick_restart_q <= 1'b0;
      wdt_reset_q <= 1'b0;
    end else begin
      tick_restart_q <= good_kick || timeout || early;
      wdt_reset_q <= timeout || early;
      if (good_kick || timeout || early || !run)
        post_q <= 15'h0000;
      else if (tick)
        post_q <= post_q + 15'h0001;
    end
  end

  // Sticky events; set beats write-one-to-clear
  wire [`WDF_EV_NUM-1:0] ev = {bad_kick, early, timeout};
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= {`WDF_EV_NUM{1'b0}};
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr_stat && ws_q[0]) ? w_q[`WDF_EV_NUM-1:0] : {`WDF_EV_NUM{1'b0}})) | ev;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == `WDF_CONFIG_OFF)
        s_axi_rdata <= {22'h0, config_q};
      else if (s_axi_araddr == `WDF_CONTROL_OFF)
        s_axi_rdata <= {29'h0, sleep_q, 1'b0, soft_en_q};
      else if (s_axi_araddr == `WDF_STATUS_OFF)
        s_axi_rdata <= {30'h0, window_open, run};
      else if (s_axi_araddr == `WDF_IRQ_STAT_OFF)
        s_axi_rdata <= {29'h0, stat_q};
      else if (s_axi_araddr == `WDF_IRQ_MASK_OFF)
        s_axi_rdata <= {29'h0, mask_q};
      else if (s_axi_araddr == `WDF_COUNT_OFF)
        s_axi_rdata <= {17'h0, post_q};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // wdf_top

// ### wdf_chk.sv
// Port checker for the fuse-configured watchdog.
// Assumes binding to wdf_top, one clock aclk.
`timescale 1ns/1ns
module wdf_chk (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire wdt_reset_q,
  input wire irq_q
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------
  // Bus timing and reset pulse
  // ------------------------------------------
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not released");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready too soon");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready too soon");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10}) else $error("bad write code");
  reset_pulse_a: assert property (wdt_reset_q |=> !wdt_reset_q [*2]) else $error("reset pulse too long");
  cover property (wdt_reset_q);
  cover property (irq_q);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // wdf_chk

bind wdf_top wdf_chk chk_u (.*);

// ### tb_wdf_top.sv
// Self-checking bench for the watchdog block.
// Assumes wdf_defs.vh offsets and a 10 MHz aclk.
`timescale 1ns/1ns
`include "wdf_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_wdf_top;
  reg aclk = 0;
  reg aresetn = 0;
  reg [11:0] s_axi_awaddr = 0;
  reg [11:0] s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0;
  reg s_axi_wvalid = 0;
  reg s_axi_arvalid = 0;
  reg s_axi_bready = 1;
  reg s_axi_rready = 1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_reset_q, irq_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_errors = 0, check_count = 0, cyc = 0, t, e, i;
  reg [31:0] rv;
  reg [1:0] rr;
  reg [9:0] cf [0:7] = '{10'h080, 10'h0c0, 10'h0c0, 10'h0a0, 10'h0a0, 10'h0a0, 10'h0e0, 10'h0e0};
  reg [2:0] ct [0:7] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h4, 3'h0};
  reg ex [0:7] = '{0, 0, 1, 1, 0, 0, 1, 1};
  integer we [0:3] = '{64, 128, 160, 192};

  wdf_top dut_u (.*);

  // Clock and cycle ceiling
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      complete_run;
    end
  end

  // ------------------------------------------
  // Bus tasks
  // ------------------------------------------
  task wr(input [11:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
    end
  endtask

  task rd(input [11:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
    end
  endtask

  // Cycles between two reset pulses
  task gap(output integer n);
    begin
      while (!wdt_reset_q) @(posedge aclk);
      @(posedge aclk);
      n = 1;
      while (!wdt_reset_q) begin
        @(posedge aclk);
        n++;
      end
    end
  endtask

  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`WDF_CONFIG_OFF); `CHK(rv, 32'h3ff)
    rd(12'h0f0); `CHK(rr, 2'b10)
    wr(12'h0f4, 1); `CHK(rr, 2'b10)
    // Prescale and postscale periods
    for (i = 0; i < 4; i++) begin
      wr(`WDF_CONFIG_OFF, 8'he0 | (i & 1) << 4 | i >> 1);
      gap(t);
      gap(t);
      e = ((i & 1) ? 128 : 32) << (i >> 1);
      `CHK(t >= e && t <= e + 2, 1'b1)
    end
    // Enable modes against soft enable and sleep
    for (i = 0; i < 8; i++) begin
      wr(`WDF_CONFIG_OFF, cf[i]);
      wr(`WDF_CONTROL_OFF, ct[i]);
      rd(`WDF_STATUS_OFF); `CHK(rv[0], ex[i])
    end
    // Stopped clear raises an event; mask and clear the interrupt
    wr(`WDF_CONFIG_OFF, 10'h080);
    wr(`WDF_IRQ_STAT_OFF, 7);
    wr(`WDF_CONTROL_OFF, 2);
    rd(`WDF_CONTROL_OFF); `CHK(rv[1:0], 2'b00)
    rd(`WDF_COUNT_OFF); `CHK(rv, 32'h0)
    rd(`WDF_IRQ_STAT_OFF); `CHK(rv[2:0], 3'b100)
    wr(`WDF_IRQ_MASK_OFF, 4);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b1)
    wr(`WDF_IRQ_MASK_OFF, 0);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    wr(`WDF_IRQ_MASK_OFF, 4);
    wr(`WDF_IRQ_STAT_OFF, 4);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    // Early clear harmless without window, fatal with one
    wr(`WDF_CONFIG_OFF, 10'h0e3);
    gap(t);
    rd(`WDF_IRQ_STAT_OFF); `CHK(rv[0], 1'b1)
    wr(`WDF_IRQ_STAT_OFF, 7);
    wr(`WDF_CONTROL_OFF, 2);
    repeat (3) @(posedge aclk);
    rd(`WDF_IRQ_STAT_OFF); `CHK(rv[1], 1'b0)
    wr(`WDF_CONFIG_OFF, 10'h363);
    gap(t);
    wr(`WDF_CONTROL_OFF, 2);
    repeat (3) @(posedge aclk);
    rd(`WDF_IRQ_STAT_OFF); `CHK(rv[1], 1'b1)
    // Window opening time per size, then a clear inside it
    for (i = 0; i < 4; i++) begin
      wr(`WDF_CONFIG_OFF, {i[1:0], 8'h63});
      wr(`WDF_IRQ_STAT_OFF, 7);
      gap(t);
      t = cyc;
      do rd(`WDF_STATUS_OFF); while (!rv[1]);
      t = cyc - t;
      `CHK(t >= we[i] - 2 && t <= we[i] + 6, 1'b1)
      wr(`WDF_CONTROL_OFF, 2);
      rd(`WDF_IRQ_STAT_OFF); `CHK(rv[1], 1'b0)
    end
    complete_run;
  end
endmodule // tb_wdf_top
